//--- rtl/fpec_top.sv
// Flash program/erase sequencer with AHB-Lite registers and serial boot loader
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Function
// R1: four array modes, only one active
// R2: program 32 bytes in one operation
// R3: erase one block at a time
// R4: twelve blocks: 7x32k, 1x28k, 4x1k
// R5: nominal 10 ms program, 100 ms erase
// R6: mode taken from pins at reset
// R7: user mode reads only, refuses program/erase
// R8: program/erase only boot, user-program, programmer
// R9: erased locations read all ones
// R10: boot mode erases whole array
// R11: user program mode erases whole blocks
// R12: boot loader stores host program in RAM
// R13: boot link measures host bit rate
// R14: emulation block reads come from overlap RAM
// R15: clearing overlap select restores flash reads
// R16: software emulates only in user modes; the code allows emulation in every mode
// R17: software programs only erased blocks; the code launches program without checking the erased map
// R18: write-protect pin blocks program and erase
// R19: high protect pin protects; flag shows inverse
// R20: program bits accepted only in order
// R21: erase bit needs erase setup first
// R22: plain writes never change the array
module fpec_top import fpec_pkg::*; #(
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic mode_select_pin3_i,
    input wire logic mode_select_pin2_i,
    input wire logic mode_select_pin1_i,
    input wire logic mode_select_pin0_i,
    input wire logic hw_write_protect_pin_i,
    input wire logic boot_serial_rx_i,
    output logic boot_serial_tx_o,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output fpec_flash_cmd_s flash_cmd_o,
    output logic [UNIT_BYTES*8-1:0] flash_wdata_o,
    output logic [ARR_AW-1:0] flash_raddr_o,
    input wire logic [31:0] flash_rdata_i,
    input wire logic [31:0] ovl_rdata_i,
    output fpec_ram_wr_s boot_ram_wr_o,
    output fpec_mode_e mode_o
);
    // ******
    // Declarations
    // ******
    typedef enum {SQ_IDLE, SQ_PROG, SQ_ERASE} fpec_seq_e;
    typedef enum {BT_IDLE, BT_ARM, BT_MEAS, BT_WAIT, BT_START, BT_BITS, BT_STOP} fpec_boot_e;
    fpec_seq_e seq_reg;
    fpec_boot_e bt_reg;
    fpec_mode_e mode_reg;
    logic cap_done_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [NUM_BLK-1:0] blksel_reg;
    logic [NUM_BLK-1:0] erased_reg;
    logic ovl_sel_reg;
    logic [3:0] emu_blk_reg;
    logic done_reg;
    logic refused_reg;
    logic [ARR_AW-1:0] paddr_reg;
    logic [ARR_AW-1:0] raddr_reg;
    logic [31:0] pbuf [UNIT_WORDS];
    logic [19:0] timer_reg;
    fpec_flash_cmd_s cmd_reg;
    logic [UNIT_BYTES*8-1:0] wdata_reg;
    logic [BAUD_W-1:0] per_reg;
    logic [BAUD_W-1:0] bcnt_reg;
    logic [3:0] bit_reg;
    logic [7:0] rx_shift_reg;
    logic locked_reg;
    fpec_ram_wr_s ram_wr_reg;
    logic [9:0] tx_shift_reg;
    logic [3:0] tx_bits_reg;
    logic [BAUD_W-1:0] tx_cnt_reg;
    logic [21:0] meas_prod;
    logic ap_valid, we, ctrl_wr, hw_en, pgm_ok, accept, emu_hit, seq_end;
    logic prog_launch, erase_launch, refuse_now, abort;
    logic [NUM_BLK-1:0] erase_set;
    logic [31:0] rd_word;
    logic [31:0] rd_mux;

    // ******
    // Mode capture and protection
    // ******
    // Pins caught at the first edge after release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_done_reg <= 1'b0;
            mode_reg <= FM_USER;
        end else if (!cap_done_reg) begin
            cap_done_reg <= 1'b1; // R6
            if ({mode_select_pin3_i, mode_select_pin2_i, mode_select_pin1_i, mode_select_pin0_i} == MP_BOOT) begin
                mode_reg <= FM_BOOT;
            end else if ({mode_select_pin3_i, mode_select_pin2_i,
                          mode_select_pin1_i, mode_select_pin0_i} == MP_PROGRAMMER) begin
                mode_reg <= FM_PROGRAMMER;
            end else if (!hw_write_protect_pin_i) begin
                mode_reg <= FM_USER_PROG;
            end else begin
                mode_reg <= FM_USER;
            end
        end
    end

    // Low protect pin enables writes
    assign hw_en = ~hw_write_protect_pin_i; // R19
    assign pgm_ok = hw_en && cap_done_reg && (mode_reg != FM_USER); // R7 R8 R18
    assign mode_o = mode_reg;

    // ******
    // AHB-Lite slave, zero wait states
    // ******
    assign ap_valid = hsel_i && hready_i && htrans_i[1];
    assign we = wr_pend_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;

    // Address phase captured for the following data phase
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= ap_valid && hwrite_i;
            wr_addr_reg <= haddr_i[7:0];
            if (ap_valid && !hwrite_i) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Array read path through the data window
    assign emu_hit = ovl_sel_reg && (fpec_blk_of(raddr_reg) == emu_blk_reg); // R14 R15
    assign flash_raddr_o = raddr_reg;
    always_comb begin
        if (emu_hit) begin
            rd_word = ovl_rdata_i; // R14
        end else if (erased_reg[fpec_blk_of(raddr_reg)]) begin
            rd_word = ERASED_WORD; // R9
        end else begin
            rd_word = flash_rdata_i;
        end
    end

    // Read decode; unmapped words read zero
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (haddr_i[7:0])
            OFF_CTRL: rd_mux = {24'h000000, hw_en, ctrl_reg[6:0]}; // R19
            OFF_BLKSEL: rd_mux = {20'h00000, blksel_reg};
            OFF_EMU: rd_mux = {23'h000000, ovl_sel_reg, 4'h0, emu_blk_reg};
            OFF_STAT: rd_mux = {26'h0000000, mode_reg, 1'b0, refused_reg, done_reg, seq_reg != SQ_IDLE};
            OFF_PADDR: rd_mux = {14'h0000, paddr_reg};
            OFF_RADDR: rd_mux = {14'h0000, raddr_reg};
            OFF_RDATA: rd_mux = rd_word;
            OFF_BOOT: rd_mux = {15'h0000, locked_reg, per_reg};
            default: begin
                if (haddr_i[7:5] == OFF_PBUF[7:5]) begin
                    rd_mux = pbuf[haddr_i[4:2]];
                end
            end
        endcase
    end

    // ******
    // Control register and launch decisions
    // ******
    // Each bit lands only once its predecessor is already set
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next[CB_SWE] = hwdata_i[CB_SWE];
        if (ctrl_reg[CB_SWE]) begin
            ctrl_next[CB_ESU] = hwdata_i[CB_ESU];
            ctrl_next[CB_PSU] = hwdata_i[CB_PSU];
            ctrl_next[CB_EV] = hwdata_i[CB_EV];
            ctrl_next[CB_PV] = hwdata_i[CB_PV];
            ctrl_next[CB_E] = hwdata_i[CB_E] && ctrl_reg[CB_ESU]; // R21
            ctrl_next[CB_P] = hwdata_i[CB_P] && ctrl_reg[CB_PSU]; // R20
        end else begin
            ctrl_next[5:0] = 6'h00;
        end
        ctrl_next[CB_HWEN] = 1'b0;
    end

    assign ctrl_wr = we && (wr_addr_reg == OFF_CTRL) && hw_en;
    // More than one mode bit at once is refused
    assign accept = ctrl_wr && ($countones({ctrl_next[CB_P], ctrl_next[CB_E],
                                 ctrl_next[CB_PV], ctrl_next[CB_EV]}) <= 1); // R1
    assign erase_set = (mode_reg == FM_BOOT) ? {NUM_BLK{1'b1}} : blksel_reg; // R10
    assign prog_launch = accept && ctrl_next[CB_P] && !ctrl_reg[CB_P] && pgm_ok && seq_reg == SQ_IDLE;
    assign erase_launch = accept && ctrl_next[CB_E] && !ctrl_reg[CB_E] && pgm_ok && seq_reg == SQ_IDLE
                          && ((mode_reg == FM_BOOT) || $onehot(blksel_reg)); // R3 R11
    assign refuse_now = (ctrl_wr && !accept)
                        || (accept && ctrl_next[CB_P] && !ctrl_reg[CB_P] && !prog_launch)
                        || (accept && ctrl_next[CB_E] && !ctrl_reg[CB_E] && !erase_launch); // R7
    // Dropping the go bit releases the running mode
    assign abort = (seq_reg == SQ_PROG && !ctrl_reg[CB_P]) || (seq_reg == SQ_ERASE && !ctrl_reg[CB_E]);

    // Refused launch leaves the go bit clear; protect clears every control bit
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RST;
        end else if (!hw_en) begin
            ctrl_reg <= CTRL_RST; // R18
        end else if (accept) begin
            ctrl_reg <= ctrl_next;
            ctrl_reg[CB_P] <= ctrl_next[CB_P] && (ctrl_reg[CB_P] || prog_launch);
            ctrl_reg[CB_E] <= ctrl_next[CB_E] && (ctrl_reg[CB_E] || erase_launch);
        end
    end

    // Block select, emulation and address registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blksel_reg <= '0;
            ovl_sel_reg <= 1'b0;
            emu_blk_reg <= 4'h0;
            paddr_reg <= '0;
            raddr_reg <= '0;
        end else if (we) begin
            if (wr_addr_reg == OFF_BLKSEL && ctrl_reg[CB_SWE]) begin
                blksel_reg <= hwdata_i[NUM_BLK-1:0];
            end
            if (wr_addr_reg == OFF_EMU) begin
                ovl_sel_reg <= hwdata_i[EMU_SEL]; // R15
                emu_blk_reg <= hwdata_i[3:0];
            end
            if (wr_addr_reg == OFF_PADDR) begin
                paddr_reg <= {hwdata_i[ARR_AW-1:5], 5'h00}; // R2
            end
            if (wr_addr_reg == OFF_RADDR) begin
                raddr_reg <= {hwdata_i[ARR_AW-1:2], 2'b00};
            end
        end
    end

    // Program unit buffer, one word per entry
    genvar g;
    generate
        for (g = 0; g < UNIT_WORDS; g++) begin : g_pbuf
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pbuf[g] <= ERASED_WORD;
                    wdata_reg[g*32 +: 32] <= ERASED_WORD;
                end else begin
                    if (we && wr_addr_reg == (OFF_PBUF + 8'(g * 4))) begin
                        pbuf[g] <= hwdata_i;
                    end
                    if (prog_launch) begin
                        wdata_reg[g*32 +: 32] <= pbuf[g]; // R2
                    end
                end
            end
        end
    endgenerate

    // ******
    // Program/erase sequencer
    // ******
    assign seq_end = (seq_reg != SQ_IDLE) && (timer_reg == 20'h00001);

    // Only this sequencer drives the array strobes
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_reg <= SQ_IDLE;
            timer_reg <= 20'h00000;
            cmd_reg <= '0;
        end else begin
            unique case (seq_reg)
                SQ_IDLE: begin
                    if (prog_launch) begin
                        seq_reg <= SQ_PROG;
                        timer_reg <= 20'(PROG_CYCLES); // R5
                        cmd_reg <= '{prog: 1'b1, erase: 1'b0, blocks: '0, addr: paddr_reg}; // R2 R22
                    end else if (erase_launch) begin
                        seq_reg <= SQ_ERASE;
                        timer_reg <= 20'(ERASE_CYCLES); // R5
                        cmd_reg <= '{prog: 1'b0, erase: 1'b1, blocks: erase_set, addr: '0}; // R3 R10
                    end
                end
                SQ_PROG, SQ_ERASE: begin
                    timer_reg <= timer_reg - 20'h00001;
                    if (seq_end || abort) begin
                        seq_reg <= SQ_IDLE;
                        cmd_reg <= '0;
                    end
                end
            endcase
        end
    end
    assign flash_cmd_o = cmd_reg;
    assign flash_wdata_o = wdata_reg;

    // Erased map; programming a block makes the array visible again
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            erased_reg <= '0;
        end else if (seq_end && seq_reg == SQ_ERASE) begin
            erased_reg <= erased_reg | cmd_reg.blocks; // R9 R4
        end else if (seq_end && seq_reg == SQ_PROG) begin
            erased_reg[fpec_blk_of(cmd_reg.addr)] <= 1'b0;
        end
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            done_reg <= seq_end || (done_reg && !(we && wr_addr_reg == OFF_STAT && hwdata_i[ST_DONE]));
            refused_reg <= refuse_now
                           || (refused_reg && !(we && wr_addr_reg == OFF_STAT && hwdata_i[ST_REFUSED]));
        end
    end

    // ******
    // Boot loader: autobaud receiver and RAM writer
    // ******
    // Host opens with a zero byte: nine low bit times measured at once
    assign meas_prod = 22'(bcnt_reg) * DIV9_MUL;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bt_reg <= BT_IDLE;
            bcnt_reg <= '0;
            per_reg <= '0;
            bit_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            locked_reg <= 1'b0;
            ram_wr_reg <= '0;
        end else begin
            ram_wr_reg.we <= 1'b0;
            bcnt_reg <= bcnt_reg + 1'b1;
            unique case (bt_reg)
                BT_IDLE: begin
                    if (cap_done_reg && mode_reg == FM_BOOT && boot_serial_rx_i) begin
                        bt_reg <= BT_ARM;
                    end
                end
                BT_ARM: begin
                    bcnt_reg <= '0;
                    if (!boot_serial_rx_i) begin
                        bt_reg <= BT_MEAS;
                    end
                end
                BT_MEAS: begin
                    if (boot_serial_rx_i) begin
                        per_reg <= BAUD_W'(meas_prod >> DIV9_SHIFT); // R13
                        locked_reg <= 1'b1;
                        bt_reg <= BT_WAIT;
                    end
                end
                BT_WAIT: begin
                    bcnt_reg <= '0;
                    if (!boot_serial_rx_i) begin
                        bt_reg <= BT_START;
                    end
                end
                BT_START: begin
                    if (bcnt_reg >= (per_reg >> 1)) begin
                        bcnt_reg <= '0;
                        bit_reg <= 4'h0;
                        bt_reg <= boot_serial_rx_i ? BT_WAIT : BT_BITS;
                    end
                end
                BT_BITS: begin
                    if (bcnt_reg >= per_reg) begin
                        bcnt_reg <= '0;
                        rx_shift_reg <= {boot_serial_rx_i, rx_shift_reg[7:1]};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            bt_reg <= BT_STOP;
                        end
                    end
                end
                BT_STOP: begin
                    if (bcnt_reg >= per_reg) begin
                        // Framing error drops the byte without moving the pointer
                        if (boot_serial_rx_i) begin
                            ram_wr_reg.we <= 1'b1; // R12
                            ram_wr_reg.data <= rx_shift_reg;
                        end
                        bt_reg <= BT_WAIT;
                    end
                end
            endcase
            if (ram_wr_reg.we) begin
                ram_wr_reg.addr <= ram_wr_reg.addr + 16'h0001;
            end
        end
    end
    assign boot_ram_wr_o = ram_wr_reg;

    // Acknowledge byte sent once at the measured rate
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_shift_reg <= 10'h3ff;
            tx_bits_reg <= 4'h0;
            tx_cnt_reg <= '0;
        end else if (bt_reg == BT_MEAS && boot_serial_rx_i) begin
            tx_shift_reg <= {1'b1, BOOT_ACK, 1'b0}; // R13
            tx_bits_reg <= 4'ha;
            tx_cnt_reg <= '0;
        end else if (tx_bits_reg != 4'h0) begin
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
            if (tx_cnt_reg >= per_reg) begin
                tx_cnt_reg <= '0;
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                tx_bits_reg <= tx_bits_reg - 4'h1;
            end
        end
    end
    assign boot_serial_tx_o = tx_shift_reg[0];
endmodule : fpec_top

//--- rtl/fpec_pkg.sv
// Package for the flash program/erase controller: offsets, fields, timing, types
package fpec_pkg;
    // ******
    // Timing
    // ******
    localparam int CLK_HZ = 10_000_000;
    localparam int PROG_TIME_MS = 10;
    localparam int ERASE_TIME_MS = 100;
    localparam int PROG_CYC = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int ERASE_CYC = ERASE_TIME_MS * (CLK_HZ / 1000);
    // ******
    // Array geometry
    // ******
    localparam int NUM_BLK = 12;
    localparam int UNIT_BYTES = 32;
    localparam int UNIT_WORDS = UNIT_BYTES / 4;
    localparam int ARR_AW = 18;
    localparam logic [17:0] SMALL_END = 18'h01000;
    localparam logic [17:0] MID_END = 18'h08000;
    localparam logic [3:0] MID_BLK = 4'h4;
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;
    // ******
    // Register offsets and fields
    // ******
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BLKSEL = 8'h04;
    localparam logic [7:0] OFF_EMU = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_PADDR = 8'h10;
    localparam logic [7:0] OFF_RADDR = 8'h14;
    localparam logic [7:0] OFF_RDATA = 8'h18;
    localparam logic [7:0] OFF_BOOT = 8'h1c;
    localparam logic [7:0] OFF_PBUF = 8'h20;
    localparam int CB_HWEN = 7;
    localparam int CB_SWE = 6;
    localparam int CB_ESU = 5;
    localparam int CB_PSU = 4;
    localparam int CB_EV = 3;
    localparam int CB_PV = 2;
    localparam int CB_E = 1;
    localparam int CB_P = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_MODE = 4;
    localparam int EMU_SEL = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ******
    // Mode pins and autobaud
    // ******
    localparam logic [3:0] MP_BOOT = 4'h8;
    localparam logic [3:0] MP_PROGRAMMER = 4'hc;
    localparam int BAUD_W = 16;
    localparam logic [21:0] DIV9_MUL = 22'h000039;
    localparam int DIV9_SHIFT = 9;
    localparam logic [7:0] BOOT_ACK = 8'h00;
    typedef enum logic [1:0] {FM_USER, FM_USER_PROG, FM_BOOT, FM_PROGRAMMER} fpec_mode_e;
    typedef struct packed {
        logic prog;
        logic erase;
        logic [NUM_BLK-1:0] blocks;
        logic [ARR_AW-1:0] addr;
    } fpec_flash_cmd_s;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } fpec_ram_wr_s;
    // Erase block index of an array byte address
    function automatic logic [3:0] fpec_blk_of(input logic [17:0] a);
        if (a < SMALL_END) begin
            return {2'b00, a[11:10]};
        end
        if (a < MID_END) begin
            return MID_BLK;
        end
        return 4'({1'b0, a[17:15]}) + MID_BLK;
    endfunction : fpec_blk_of
endpackage : fpec_pkg

//--- bench/fpec_top_asserts.sv
// Port checker for the flash program/erase sequencer
`timescale 1ns/1ps
module fpec_checker import fpec_pkg::*; #(
    parameter int PROG_CYCLES = PROG_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic hw_write_protect_pin_i,
    input wire fpec_flash_cmd_s flash_cmd_o,
    input wire fpec_ram_wr_s boot_ram_wr_o,
    input wire fpec_mode_e mode_o
);
    wire logic prog = flash_cmd_o.prog;
    wire logic ers = flash_cmd_o.erase;
    // Operation length, counted rather than repeated
    int run_cnt;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= (prog || ers) ? run_cnt + 1 : 0;
        end
    end
    // ******
    // Assertions
    // ******
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    one_mode_a: assert property (!(prog && ers))
        else $error("program and erase together");
    user_refuse_a: assert property (mode_o == FM_USER |-> !prog && !ers)
        else $error("operation in user mode");
    protect_launch_a: assert property ($rose(prog) || $rose(ers) |-> !$past(hw_write_protect_pin_i))
        else $error("launch while protected");
    prog_len_a: assert property ($fell(prog) |-> run_cnt == PROG_CYCLES)
        else $error("program length wrong");
    one_block_a: assert property ($rose(ers) && mode_o != FM_BOOT |-> $onehot(flash_cmd_o.blocks))
        else $error("erase not one block");
    boot_all_a: assert property (ers && mode_o == FM_BOOT |-> flash_cmd_o.blocks == 12'hfff)
        else $error("boot erase not whole array");
    ram_step_a: assert property (boot_ram_wr_o.we |=> !boot_ram_wr_o.we ##0
        boot_ram_wr_o.addr == $past(boot_ram_wr_o.addr) + 16'h0001)
        else $error("loader write not a stepping pulse");
    mode_hold_a: assert property ($past(rstn_i, 2) |-> $stable(mode_o))
        else $error("mode changed after reset");
endmodule : fpec_checker

//--- bench/fpec_host_model.sv
// Host side of the boot serial link
`timescale 1ns/1ps
module fpec_host_model #(
    parameter int BIT_NS = 1600
) (
    output logic rxd_o
);
    // Idle line is high
    initial begin
        rxd_o = 1'b1;
    end
    // 8N1 frame, low bit first
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= frame[i];
            #(BIT_NS);
        end
    endtask : send_byte
endmodule : fpec_host_model

//--- bench/tb.sv
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
module tb import fpec_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] md = 4'h0;
    logic wp = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hrdy, rxd, txd, hresp;
    logic [17:0] fraddr;
    fpec_mode_e mode;
    fpec_flash_cmd_s cmd;
    logic [255:0] wdata;
    fpec_ram_wr_s ram_wr;
    logic [7:0] ram_q[$];
    int n_mismatch = 0;
    int n_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    fpec_top #(.PROG_CYCLES(20), .ERASE_CYCLES(50)) dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mode_select_pin3_i(md[3]), .mode_select_pin2_i(md[2]),
        .mode_select_pin1_i(md[1]), .mode_select_pin0_i(md[0]), .hw_write_protect_pin_i(wp),
        .boot_serial_rx_i(rxd), .boot_serial_tx_o(txd), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .flash_cmd_o(cmd), .flash_wdata_o(wdata), .flash_raddr_o(fraddr),
        .flash_rdata_i({14'h0, fraddr}), .ovl_rdata_i(32'hc3c3c3c3), .boot_ram_wr_o(ram_wr), .mode_o(mode));
    fpec_host_model host (.rxd_o(rxd));
    // Catch each loader write pulse
    always @(posedge clk_sys_i) begin
        if (ram_wr.we === 1'b1) begin
            ram_q.push_back(ram_wr.data);
        end
    end
    // ******
    // Bus and check tasks
    // ******
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_wait();
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    endtask : bus_wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        bus_wait();
        htrans <= 2'h0;
        bus_wait();
        d = hrdata;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
        chk(32'(hresp), 32'h0);
    endtask : rchk
    // Pins steady across release
    task automatic restart(input logic [3:0] pins, input logic pin_wp);
        rstn_i <= 1'b0;
        md <= pins;
        wp <= pin_wp;
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask : restart
    // Enable, select, setup, go
    task automatic launch(input logic [7:0] su, input logic [7:0] go, input logic [31:0] blk);
        wr(OFF_CTRL, 32'h40);
        wr(OFF_BLKSEL, blk);
        wr(OFF_CTRL, {24'h0, su});
        wr(OFF_CTRL, {24'h0, go});
        @(posedge clk_sys_i);
    endtask : launch
    task automatic wait_done();
        logic [31:0] s = 32'h0;
        for (int i = 0; i < 40 && s[1] !== 1'b1; i++) begin
            rd(OFF_STAT, s);
        end
        chk(32'(s[1]), 32'h1);
        wr(OFF_STAT, 32'h6);
    endtask : wait_done
    // ******
    // Scenarios
    // ******
    task automatic t_user();
        restart(4'h0, 1'b1);
        rchk(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h40);
        rchk(OFF_CTRL, 32'h0);
        wp <= 1'b0;
        rchk(OFF_CTRL, 32'h80);
        launch(8'h50, 8'h51, 32'h0);
        rchk(OFF_STAT, 32'h4);
    endtask : t_user
    task automatic t_uprog();
        restart(4'h0, 1'b0);
        rchk(OFF_STAT, 32'h10);
        chk(32'(mode), 32'h1);
        wr(OFF_CTRL, 32'h40);
        wr(OFF_CTRL, 32'h41);
        rchk(OFF_CTRL, 32'hc0);
        wr(OFF_CTRL, 32'h42);
        rchk(OFF_CTRL, 32'hc0);
        wr(OFF_CTRL, 32'h4c);
        rchk(OFF_STAT, 32'h14);
        wr(OFF_STAT, 32'h6);
        wr(8'h44, 32'h0);
        rchk(8'h44, 32'h0);
        wr(OFF_RADDR, 32'h8000);
        rchk(OFF_RDATA, 32'h8000);
        wr(OFF_EMU, 32'h105);
        rchk(OFF_RDATA, 32'hc3c3c3c3);
        wr(OFF_EMU, 32'h5);
        rchk(OFF_RDATA, 32'h8000);
        launch(8'h60, 8'h62, 32'h20);
        chk({20'h0, cmd.blocks}, 32'h20);
        wait_done();
        rchk(OFF_RDATA, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            wr(OFF_PBUF + 8'(4 * i), 32'ha0000000 + 32'(i));
        end
        wr(OFF_PADDR, 32'h8000);
        launch(8'h50, 8'h51, 32'h0);
        rchk(OFF_STAT, 32'h11);
        chk({wdata[255:224], 14'h0, cmd.addr} == {32'ha0000007, 32'h8000}, 32'h1);
        wait_done();
        rchk(OFF_RDATA, 32'h8000);
    endtask : t_uprog
    task automatic t_boot();
        logic [31:0] d;
        restart(MP_BOOT, 1'b0);
        chk(32'(mode), 32'h2);
        host.send_byte(8'h00);
        wait (txd === 1'b0);
        repeat (200) @(posedge clk_sys_i);
        rd(OFF_BOOT, d);
        chk(32'(d[16] && d[15:0] >= 16'h000f && d[15:0] <= 16'h0010), 32'h1);
        host.send_byte(8'ha5);
        host.send_byte(8'h3c);
        repeat (4) @(posedge clk_sys_i);
        chk({16'h0, ram_q[0], ram_q[1]}, 32'ha53c);
        launch(8'h60, 8'h62, 32'h0);
        chk({20'h0, cmd.blocks}, 32'hfff);
        wait_done();
    endtask : t_boot
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        t_user();
        t_uprog();
        t_boot();
        close_out();
    end
    // Watchdog, 20000 cycles
    initial begin
        #(20000 * 100);
        n_mismatch++;
        close_out();
    end
endmodule : tb
bind fpec_top fpec_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hw_write_protect_pin_i(hw_write_protect_pin_i),
    .flash_cmd_o(flash_cmd_o), .boot_ram_wr_o(boot_ram_wr_o), .mode_o(mode_o));
